// ### sbd_defs.vh
// Register indices, field positions and reset values of the buffer port.
`ifndef SBD_DEFS_VH
`define SBD_DEFS_VH
`define SBD_IDX_LP_LOW      16'hfc66
`define SBD_IDX_CP_LP_HIGH  16'hfc67
`define SBD_IDX_CTRL        16'hfc68
`define SBD_IDX_ADDR        16'hfc69
`define SBD_IDX_WPORT       16'hfc6a
`define SBD_IDX_RPORT       16'hfc6b
`define SBD_IDX_STATUS      16'hfc6c
`define SBD_IDX_BASE0       16'hfc70
`define SBD_IDX_BASE3       16'hfc73
`define SBD_CF_RD_EN        0
`define SBD_CF_WR_EN        1
`define SBD_CF_ECC_EN       8
`define SBD_CF_ECC_CLR      9
`define SBD_CF_SEL_LSB      12
`define SBD_CF_SEL_MSB      15
`define SBD_ST_IRQ_EN       14
`define SBD_ST_SLV_ERR      9
`define SBD_ST_W1C_MASK     15'h3dff
`define SBD_CTRL_RESET      16'h0000
`define SBD_ADDR_RESET      11'h000
`define SBD_STATUS_RESET    15'h0000
`define SBD_DATA_RESET      16'h0000
`define SBD_MEM_WORDS       1536
`define SBD_RESP_OKAY       2'b00
`define SBD_RESP_SLVERR     2'b10
`endif

// ### sbd_engine_model.sv
// Engine model that reaches the buffer through its base region.
module sbd_engine_model (
    input  logic        aclk,
    output logic        periph_req,
    output logic [1:0]  periph_sel,
    output logic        periph_we,
    output logic [10:0] periph_offset,
    output logic [15:0] periph_wdata,
    input  logic        periph_busy,
    input  logic        periph_ack,
    input  logic [15:0] periph_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        periph_req = 1'b0;
        periph_sel = 2'b00;
        periph_we = 1'b0;
        periph_offset = 11'h000;
        periph_wdata = 16'h5a5a;
    end
    // One request, then wait for its answer; data lines turn over after.
    task automatic access(input logic w, input logic [1:0] s,
        input logic [10:0] o, input logic [15:0] d,
        output logic [15:0] q, output logic ok);
        int n;
        begin
            @(posedge aclk);
            periph_req <= 1'b1;
            periph_we <= w;
            periph_sel <= s;
            periph_offset <= o;
            periph_wdata <= d;
            @(posedge aclk);
            periph_req <= 1'b0;
            n = 0;
            while (periph_ack !== 1'b1 && n < 40)
            begin
                @(posedge aclk);
                n++;
            end
            q = periph_rdata;
            ok = (n < 40);
            periph_wdata <= ~d;
        end
    endtask
endmodule

// ### sbd_mem.v
// Flip-flop word store with one synchronous read/write port.
`include "sbd_defs.vh"
module sbd_mem #(
    parameter DEPTH = `SBD_MEM_WORDS,
    parameter AW    = 11,
    parameter DW    = 16
) (
    input  wire          aclk,
    input  wire          aresetn,
    input  wire          en,
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] store [0:DEPTH-1];
    wire         in_range = ({1'b0, addr} < DEPTH);

    // Words past the end ignore writes and read as zero.
    always @(posedge aclk)
    begin
        if (en && we && in_range)
        begin
            store[addr] <= wdata;
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rdata <= {DW{1'b0}};
        end
        else if (en && !we)
        begin
            rdata <= in_range ? store[addr] : {DW{1'b0}};
        end
    end
endmodule

// ### sbd_port.v
// Processor access port, arbiter, parity unit and event status of the buffer.
`include "sbd_defs.vh"
module sbd_port #(
    parameter ADDR_W = 18,
    parameter AW     = 11,
    parameter NSRC   = 16
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire              periph_req,
    input  wire [1:0]        periph_sel,
    input  wire              periph_we,
    input  wire [AW-1:0]     periph_offset,
    input  wire [15:0]       periph_wdata,
    output reg               periph_busy,
    output reg               periph_ack,
    output reg  [15:0]       periph_rdata,
    input  wire [NSRC*16-1:0] codec_sources,
    output reg  [15:0]       codec_output_data,
    input  wire [3:0]        ring_events,
    input  wire [8:0]        engine_events,
    input  wire              slave_start_seen,
    input  wire              slave_partial_stop,
    output reg               buffer_peripheral_irq
);
    reg  [15:0]   ctrl_reg;
    reg  [AW-1:0] addr_reg;
    reg  [15:0]   wport_reg;
    reg  [15:0]   stage1_reg;
    reg  [15:0]   stage2_reg;
    reg           fetch_reg;
    reg  [17:0]   line_parity_reg;
    reg  [5:0]    column_parity_reg;
    reg  [8:0]    byte_cnt_reg;
    reg  [14:0]   status_reg;
    reg  [14:0]   status_next;
    reg  [4*AW-1:0] bases_reg;
    reg  [ADDR_W-1:0] waddr_reg;
    reg  [31:0]   wdata_reg;
    reg  [3:0]    wstrb_reg;
    reg           aw_held_reg;
    reg           w_held_reg;
    reg           pend_reg;
    reg           pend_we_reg;
    reg  [AW-1:0] pend_addr_reg;
    reg  [15:0]   pend_wdata_reg;
    reg           gnt_d_reg;
    reg           gnt_we_reg;
    reg  [15:0]   rd_mux;
    reg           rd_ok;
    reg           wr_ok;
    reg  [23:0]   ecc_a;
    reg  [23:0]   ecc_b;
    reg  [15:0]   ecc_word;
    wire [15:0]   mem_q;
    wire [15:0]   widx = waddr_reg[17:2];
    wire [15:0]   ridx = s_axi_araddr[17:2];
    wire [15:0]   wd = merge16(16'h0000, wdata_reg[15:0], wstrb_reg[1:0]);
    wire [15:0]   addr_wr = merge16({{(16-AW){1'b0}}, addr_reg},
                                    wdata_reg[15:0], wstrb_reg[1:0]);
    wire          do_read = s_axi_arready && s_axi_arvalid;
    wire          do_write = aw_held_reg && w_held_reg && !s_axi_bvalid
                             && !do_read;
    wire          cpu_rd = do_read && (ridx == `SBD_IDX_RPORT)
                           && ctrl_reg[`SBD_CF_RD_EN];
    wire          cpu_wr = do_write && (widx == `SBD_IDX_WPORT)
                           && ctrl_reg[`SBD_CF_WR_EN];
    wire          cpu_op = cpu_rd || cpu_wr;
    wire          gnt = pend_reg && !cpu_op;
    wire          mem_we = cpu_op ? cpu_wr : pend_we_reg;
    wire [AW-1:0] mem_addr = cpu_op ? addr_reg : pend_addr_reg;
    wire [15:0]   mem_wd = cpu_op ? wd : pend_wdata_reg;
    wire [3:0]    src_sel = ctrl_reg[`SBD_CF_SEL_MSB:`SBD_CF_SEL_LSB];
    wire          ecc_step = (cpu_op && ctrl_reg[`SBD_CF_ECC_EN]);

    // Byte-lane merge of a register value with written data.
    function [15:0] merge16;
        input [15:0] old;
        input [15:0] nw;
        input [1:0]  strb;
        begin
            merge16 = {strb[1] ? nw[15:8] : old[15:8],
                       strb[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    // True when a word index names an implemented register.
    function mapped;
        input [15:0] idx;
        begin
            mapped = (idx >= `SBD_IDX_LP_LOW && idx <= `SBD_IDX_STATUS)
                     || (idx >= `SBD_IDX_BASE0 && idx <= `SBD_IDX_BASE3);
        end
    endfunction

    // Folds one byte into line and column parity; idx is the byte number.
    function [23:0] ecc_byte;
        input [17:0] lp;
        input [5:0]  cp;
        input [8:0]  idx;
        input [7:0]  b;
        reg   [17:0] l;
        reg   [5:0]  c;
        reg          p;
        integer      i;
        integer      j;
        integer      k;
        begin
            l = lp;
            c = cp;
            p = ^b;
            for (i = 0; i < 9; i = i + 1)
            begin
                if (idx[i])
                    l[2*i+1] = l[2*i+1] ^ p;
                else
                    l[2*i] = l[2*i] ^ p;
            end
            for (j = 0; j < 3; j = j + 1)
            begin
                for (k = 0; k < 8; k = k + 1)
                begin
                    if (((k >> j) & 1) == 1)
                        c[2*j+1] = c[2*j+1] ^ b[k];
                    else
                        c[2*j] = c[2*j] ^ b[k];
                end
            end
            ecc_byte = {l, c};
        end
    endfunction

    sbd_mem #(
        .DEPTH (`SBD_MEM_WORDS),
        .AW    (AW),
        .DW    (16)
    ) u_mem (
        .aclk    (aclk),
        .aresetn (aresetn),
        .en      (cpu_op || gnt),
        .we      (mem_we),
        .addr    (mem_addr),
        .wdata   (mem_wd),
        .rdata   (mem_q)
    );

    always @*
    begin
        ecc_word = cpu_wr ? wd : stage2_reg;
        ecc_a = ecc_byte(line_parity_reg, column_parity_reg,
                         byte_cnt_reg, ecc_word[7:0]);
        ecc_b = ecc_byte(ecc_a[23:6], ecc_a[5:0],
                         {byte_cnt_reg[8:1], 1'b1}, ecc_word[15:8]);
    end

    always @*
    begin
        rd_ok = mapped(ridx);
        case (ridx)
            `SBD_IDX_LP_LOW:     rd_mux = line_parity_reg[15:0];
            `SBD_IDX_CP_LP_HIGH: rd_mux = {8'h00, column_parity_reg,
                                           line_parity_reg[17:16]};
            `SBD_IDX_CTRL:       rd_mux = ctrl_reg;
            `SBD_IDX_ADDR:       rd_mux = {{(16-AW){1'b0}}, addr_reg};
            `SBD_IDX_WPORT:      rd_mux = wport_reg;
            `SBD_IDX_RPORT:      rd_mux = stage2_reg;
            `SBD_IDX_STATUS:     rd_mux = {1'b0, status_reg};
            default:
            begin
                if (rd_ok)
                    rd_mux = {{(16-AW){1'b0}},
                              bases_reg[ridx[1:0]*AW +: AW]};
                else
                    rd_mux = 16'h0000;
            end
        endcase
    end

    always @*
    begin
        wr_ok = mapped(widx);
        status_next = status_reg;
        if (do_write && widx == `SBD_IDX_STATUS)
        begin
            status_next = status_reg & ~(wd[14:0] & `SBD_ST_W1C_MASK);
            if (wstrb_reg[1])
                status_next[`SBD_ST_IRQ_EN] = wd[`SBD_ST_IRQ_EN];
        end
        // Events set after the clear so a same-cycle event is kept.
        status_next[13:10] = status_next[13:10] | ring_events;
        status_next[8:0] = status_next[8:0] | engine_events;
        if (slave_partial_stop)
            status_next[`SBD_ST_SLV_ERR] = 1'b1;
        else if (slave_start_seen)
            status_next[`SBD_ST_SLV_ERR] = 1'b0;
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SBD_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `SBD_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            waddr_reg <= {ADDR_W{1'b0}};
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            ctrl_reg <= `SBD_CTRL_RESET;
            addr_reg <= `SBD_ADDR_RESET;
            wport_reg <= `SBD_DATA_RESET;
            stage1_reg <= `SBD_DATA_RESET;
            stage2_reg <= `SBD_DATA_RESET;
            fetch_reg <= 1'b0;
            line_parity_reg <= 18'h00000;
            column_parity_reg <= 6'h00;
            byte_cnt_reg <= 9'h000;
            status_reg <= `SBD_STATUS_RESET;
            bases_reg <= {4*AW{1'b0}};
            buffer_peripheral_irq <= 1'b0;
            codec_output_data <= `SBD_DATA_RESET;
            pend_reg <= 1'b0;
            pend_we_reg <= 1'b0;
            pend_addr_reg <= {AW{1'b0}};
            pend_wdata_reg <= `SBD_DATA_RESET;
            gnt_d_reg <= 1'b0;
            gnt_we_reg <= 1'b0;
            periph_busy <= 1'b0;
            periph_ack <= 1'b0;
            periph_rdata <= `SBD_DATA_RESET;
        end
        else
        begin
            s_axi_awready <= !s_axi_awready && !aw_held_reg && s_axi_awvalid;
            s_axi_wready <= !s_axi_wready && !w_held_reg && s_axi_wvalid;
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid
                             && s_axi_arvalid;
            if (s_axi_awready && s_axi_awvalid)
            begin
                aw_held_reg <= 1'b1;
                waddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wready && s_axi_wvalid)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            ctrl_reg[`SBD_CF_ECC_CLR] <= 1'b0;
            if (do_read)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {16'h0000, rd_mux};
                s_axi_rresp <= rd_ok ? `SBD_RESP_OKAY : `SBD_RESP_SLVERR;
            end
            if (do_write)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `SBD_RESP_OKAY : `SBD_RESP_SLVERR;
                case (widx)
                    `SBD_IDX_CTRL:  ctrl_reg <= merge16(ctrl_reg,
                                    wdata_reg[15:0], wstrb_reg[1:0]);
                    `SBD_IDX_ADDR:  addr_reg <= addr_wr[AW-1:0];
                    `SBD_IDX_WPORT: wport_reg <= wd;
                    default:
                    begin
                        if (wr_ok && widx >= `SBD_IDX_BASE0)
                            bases_reg[widx[1:0]*AW +: AW] <=
                                wdata_reg[AW-1:0];
                    end
                endcase
            end
            if (cpu_op)
                addr_reg <= addr_reg + {{(AW-1){1'b0}}, 1'b1};
            if (cpu_rd)
                stage2_reg <= stage1_reg;
            fetch_reg <= cpu_rd;
            if (fetch_reg)
                stage1_reg <= mem_q;
            if (ctrl_reg[`SBD_CF_ECC_CLR])
            begin
                line_parity_reg <= 18'h00000;
                column_parity_reg <= 6'h00;
                byte_cnt_reg <= 9'h000;
            end
            else if (ecc_step)
            begin
                line_parity_reg <= ecc_b[23:6];
                column_parity_reg <= ecc_b[5:0];
                byte_cnt_reg <= byte_cnt_reg + 9'h002;
            end
            status_reg <= status_next;
            buffer_peripheral_irq <= status_next[`SBD_ST_IRQ_EN]
                                     && (|status_next[13:0]);
            codec_output_data <= codec_sources[src_sel*16 +: 16];
            if (periph_req && !periph_busy)
            begin
                pend_reg <= 1'b1;
                periph_busy <= 1'b1;
                pend_we_reg <= periph_we;
                pend_wdata_reg <= periph_wdata;
                pend_addr_reg <= bases_reg[periph_sel*AW +: AW]
                                 + periph_offset;
            end
            if (gnt)
                pend_reg <= 1'b0;
            gnt_d_reg <= gnt;
            gnt_we_reg <= pend_we_reg;
            periph_ack <= gnt_d_reg;
            if (gnt_d_reg)
            begin
                periph_busy <= 1'b0;
                if (!gnt_we_reg)
                    periph_rdata <= mem_q;
            end
        end
    end
endmodule

// ### sbd_port_sva.sv
// Port timing checker of the buffer port.
module sbd_port_chk (
    input logic aclk,
    input logic aresetn,
    input logic s_axi_awready,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic periph_req,
    input logic periph_busy,
    input logic periph_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_eng_take;
        periph_req && !periph_busy;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_ack_bound:
        assert property (s_eng_take |-> ##[3:40] periph_ack)
        else $error("engine answer missing");
    a_busy_hold:
        assert property (s_eng_take |=> (periph_busy && !periph_ack) [*2])
        else $error("engine busy window wrong");
    a_ack_frees:
        assert property (periph_ack |-> !periph_busy ##1 !periph_ack)
        else $error("engine ack not a free pulse");
    a_read_answer:
        assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read answer late");
    a_rvalid_drop:
        assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not released");
    a_one_read:
        assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_aw_pulse:
        assert property (s_axi_awready |=> !s_axi_awready)
        else $error("write address ready not a pulse");
    a_bvalid_drop:
        assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not released");
endmodule
bind sbd_port sbd_port_chk u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .periph_req(periph_req), .periph_busy(periph_busy),
    .periph_ack(periph_ack)
);

// ### sbd_port_tb.sv
// Self-checking bench of the shared buffer processor port.
module sbd_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic         aclk = 1'b0;
    logic         aresetn = 1'b0;
    logic [17:0]  s_axi_awaddr = 18'h00000;
    logic [17:0]  s_axi_araddr = 18'h00000;
    logic [31:0]  s_axi_wdata = 32'h00000000;
    logic         s_axi_awvalid = 1'b0;
    logic         s_axi_wvalid = 1'b0;
    logic         s_axi_bready = 1'b0;
    logic         s_axi_arvalid = 1'b0;
    logic         s_axi_rready = 1'b0;
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic         s_axi_arready, s_axi_rvalid;
    logic [1:0]   s_axi_bresp, s_axi_rresp, periph_sel, r;
    logic [31:0]  s_axi_rdata;
    logic         periph_req, periph_we, periph_busy, periph_ack, ok;
    logic [10:0]  periph_offset;
    logic [15:0]  periph_wdata, periph_rdata, codec_output_data, k, q, eq;
    logic [255:0] codec_sources;
    logic [3:0]   ring_events = 4'h0;
    logic [8:0]   engine_events = 9'h000;
    logic         slave_start_seen = 1'b0;
    logic         slave_partial_stop = 1'b0;
    logic         buffer_peripheral_irq;
    logic [12:0]  v;
    int           miscompares = 0;
    int           checked = 0;
    sbd_port dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .periph_req(periph_req), .periph_sel(periph_sel),
        .periph_we(periph_we), .periph_offset(periph_offset),
        .periph_wdata(periph_wdata), .periph_busy(periph_busy),
        .periph_ack(periph_ack), .periph_rdata(periph_rdata),
        .codec_sources(codec_sources), .codec_output_data(codec_output_data),
        .ring_events(ring_events), .engine_events(engine_events),
        .slave_start_seen(slave_start_seen),
        .slave_partial_stop(slave_partial_stop),
        .buffer_peripheral_irq(buffer_peripheral_irq)
    );
    sbd_engine_model eng (
        .aclk(aclk), .periph_req(periph_req), .periph_sel(periph_sel),
        .periph_we(periph_we), .periph_offset(periph_offset),
        .periph_wdata(periph_wdata), .periph_busy(periph_busy),
        .periph_ack(periph_ack), .periph_rdata(periph_rdata)
    );
    initial
    begin
        for (int n = 0; n < 16; n++)
            codec_sources[16*n +: 16] = 16'hc000 + 16'(n);
    end
    always #20 aclk = ~aclk;
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic conclude();
        if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [15:0] i, input logic [15:0] d);
        int n;
        begin
            @(posedge aclk);
            s_axi_awaddr <= {i, 2'b00};
            s_axi_wdata <= {16'h0000, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            n = 0;
            do
            begin
                @(posedge aclk);
                if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
                if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
                n++;
            end while (s_axi_bvalid !== 1'b1 && n < 50);
            s_axi_bready <= 1'b0;
            chk("bvalid", 1, n < 50);
            if (n >= 50) conclude();
            chk("bresp", 2'b00, s_axi_bresp);
        end
    endtask
    task automatic rd(input logic [15:0] i, output logic [15:0] d,
        output logic [1:0] rr);
        int n;
        begin
            @(posedge aclk);
            s_axi_araddr <= {i, 2'b00};
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            n = 0;
            do
            begin
                @(posedge aclk);
                if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
                n++;
            end while (s_axi_rvalid !== 1'b1 && n < 50);
            s_axi_rready <= 1'b0;
            chk("rvalid", 1, n < 50);
            if (n >= 50) conclude();
            d = s_axi_rdata[15:0];
            rr = s_axi_rresp;
        end
    endtask
    task automatic rchk(input logic [15:0] i, input logic [15:0] e);
        rd(i, q, r);
        chk("rdata", e, q);
        chk("rresp", 2'b00, r);
    endtask
    task automatic ev(input logic [3:0] re, input logic [8:0] ee,
        input logic ss, input logic sp);
        @(posedge aclk);
        ring_events <= re;
        engine_events <= ee;
        slave_start_seen <= ss;
        slave_partial_stop <= sp;
        @(posedge aclk);
        ring_events <= 4'h0;
        engine_events <= 9'h000;
        slave_start_seen <= 1'b0;
        slave_partial_stop <= 1'b0;
    endtask
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (k = 16'hfc66; k <= 16'hfc6c; k++)
            rchk(k, 16'h0000);
        rd(16'hfc6d, q, r);
        chk("unmapped rresp", 2'b10, r);
        wr(16'hfc68, 16'h0102);
        wr(16'hfc69, 16'h05ff);
        wr(16'hfc6a, 16'h0001);
        rchk(16'hfc69, 16'h0600);
        rchk(16'hfc66, 16'h5555);
        rchk(16'hfc67, 16'h0055);
        wr(16'hfc68, 16'h0002);
        wr(16'hfc6a, 16'h00ff);
        rchk(16'hfc66, 16'h5555);
        wr(16'hfc68, 16'h0202);
        rchk(16'hfc68, 16'h0002);
        rchk(16'hfc66, 16'h0000);
        rchk(16'hfc67, 16'h0000);
        wr(16'hfc69, 16'h07ff);
        wr(16'hfc6a, 16'h1234);
        rchk(16'hfc69, 16'h0000);
        for (k = 0; k < 4; k++)
            wr(16'hfc6a, 16'h1000 + k);
        rchk(16'hfc69, 16'h0004);
        wr(16'hfc68, 16'h0001);
        wr(16'hfc69, 16'h0000);
        rchk(16'hfc6b, 16'h0000);
        rchk(16'hfc6b, 16'h0000);
        for (k = 0; k < 3; k++)
            rchk(16'hfc6b, 16'h1000 + k);
        rchk(16'hfc69, 16'h0005);
        wr(16'hfc71, 16'h0100);
        eng.access(1'b1, 2'd1, 11'h003, 16'hbeef, q, ok);
        chk("engine ack", 1, ok);
        wr(16'hfc69, 16'h0103);
        fork
            eng.access(1'b0, 2'd0, 11'h002, 16'h0000, eq, ok);
            repeat (3) rd(16'hfc6b, q, r);
        join
        chk("engine rdata", 16'h1002, eq);
        chk("port rdata", 16'hbeef, q);
        for (k = 0; k < 16; k++)
        begin
            wr(16'hfc68, {k[3:0], 12'h000});
            repeat (2) @(posedge aclk);
            chk("codec out", 16'hc000 + k, codec_output_data);
        end
        ev(4'h1, 9'h1ff, 1'b0, 1'b1);
        rchk(16'hfc6c, 16'h07ff);
        chk("irq", 0, buffer_peripheral_irq);
        wr(16'hfc6c, 16'h440f);
        rchk(16'hfc6c, 16'h43f0);
        chk("irq", 1, buffer_peripheral_irq);
        ev(4'h0, 9'h000, 1'b1, 1'b0);
        rchk(16'hfc6c, 16'h41f0);
        wr(16'hfc6c, 16'h01f0);
        rchk(16'hfc6c, 16'h0000);
        for (k = 0; k < 13; k++)
        begin
            v = 13'h0001 << k;
            ev(v[12:9], v[8:0], 1'b0, 1'b0);
            rchk(16'hfc6c, {2'b00, v[12:9], 1'b0, v[8:0]});
            chk("irq", 0, buffer_peripheral_irq);
            wr(16'hfc6c, {2'b00, v[12:9], 1'b0, v[8:0]});
        end
        rchk(16'hfc6c, 16'h0000);
        conclude();
    end
endmodule
